// >>> sla_pkg.sv
// Purpose: Constants for the secure life-cycle and access control block
// Assumes: APB register map, 32-bit data, one word per register
// Notes:   Constants only; no logic lives here
// Function
// - Power-on reset loads every register, MPU included, with its default
// - ROM and flash access attributes take defaults at reset
// - MPU holds base, limit and attribute per flash and RAM partition
// - User-mode accesses checked against partition attributes set by privileged code
// - Mode selector sets ROM and flash protection attributes for user mode
// - Normal mode, once entered, can never return to test mode
// - Test mode entered only with the correct administrator password
// - Normal mode rejects every test-mode command
// - Functional test operations offered only in test mode
// - Traceability area writable only in test mode, read-only afterwards
// - Exactly one boot domain at a time, ROM or flash
// - Boot mode locked after switching to flash; later changes blocked
// - Loader commands accepted in ROM boot, refused in flash boot
// - Locked flash boot denies loader flash reads and writes
// - ROM hiding makes ROM inaccessible; ROM accesses then denied
// - Flash read-only attribute refuses flash writes
// - Reset randomizes triple-DES key registers; overwrite destroys old key
// - Reset randomizes AES key registers; overwrite destroys old key
// - Invalid or prohibited address accesses are flagged
package sla_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_LIFE   = 8'h00;
  localparam logic [7:0] OFF_PASS   = 8'h04;
  localparam logic [7:0] OFF_BOOT   = 8'h08;
  localparam logic [7:0] OFF_MODESEL = 8'h0c;
  localparam logic [7:0] OFF_STAT   = 8'h10;
  localparam logic [7:0] OFF_MPU    = 8'h40;
  localparam logic [7:0] OFF_MPU_E  = 8'h80;
  localparam logic [7:0] OFF_KEY    = 8'h80;
  localparam logic [7:0] OFF_KEY_E  = 8'hb8;
  localparam logic [1:0] FLD_BASE   = 2'h0;
  localparam logic [1:0] FLD_LIMIT  = 2'h1;
  localparam logic [1:0] FLD_ATTR   = 2'h2;
  // ---------------------------------------------------------------
  // Sizes and field positions
  // ---------------------------------------------------------------
  localparam int NPART      = 2;
  localparam int NREG       = 2 * NPART;
  localparam int KEY_WORDS  = 14;
  localparam int TDES_WORDS = 6;
  localparam int BOOT_FLASH = 0;
  localparam int BOOT_LOCK  = 1;
  localparam int OPR_HIDE   = 0;
  localparam int OPR_RO     = 1;
  localparam int OPR_RUSER  = 2;
  localparam int OPR_FUSER  = 3;
  localparam int ATTR_UR    = 0;
  localparam int ATTR_UW    = 1;
  localparam int ST_VIOL    = 0;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [3:0]  OPR_RST   = 4'hc;
  localparam logic [1:0]  ATTR_RST  = 2'h0;
  localparam logic [31:0] BASE_RST  = 32'h0000_0000;
  localparam logic [31:0] LIMIT_RST = 32'h0000_0000;
  localparam logic [31:0] KEY_RST   = 32'h0000_0000;
  // ---------------------------------------------------------------
  // Memory map
  // ---------------------------------------------------------------
  localparam logic [31:0] ROM_LO   = 32'h0000_0000;
  localparam logic [31:0] ROM_HI   = 32'h0000_ffff;
  localparam logic [31:0] FLASH_LO = 32'h0010_0000;
  localparam logic [31:0] FLASH_HI = 32'h001f_ffff;
  localparam logic [31:0] TRACE_LO = 32'h001f_f000;
  localparam logic [31:0] RAM_LO   = 32'h0020_0000;
  localparam logic [31:0] RAM_HI   = 32'h0020_ffff;

  typedef enum logic [1:0] {PH_LOAD, PH_FILL, PH_RUN} sla_phase_t;
endpackage

// >>> sla_ctrl.sv
// Purpose: Life-cycle, boot domain, memory protection and key reset logic
// Assumes: APB slave with zero wait state; memory answers in the request cycle
// Notes:   All outputs registered; pprot[0] high marks privileged software
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module sla_ctrl #(
  parameter logic [31:0] TEST_PASSWORD = 32'h5a5a_a5a5  // arbitrary value
) (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [2:0]  pprot,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic        mem_user,
  input  wire logic        mem_loader,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_rdata_in,
  output logic             mem_grant,
  output logic             mem_deny,
  output logic [31:0]      mem_rdata,
  input  wire logic        apdu_valid,
  output logic             apdu_accept,
  output logic             apdu_reject,
  input  wire logic        tcmd_valid,
  output logic             tcmd_accept,
  output logic             tcmd_reject,
  input  wire logic        nv_normal,
  input  wire logic        nv_flash_boot,
  input  wire logic        nv_boot_lock,
  output logic             nv_set_normal,
  output logic             nv_set_lock,
  input  wire logic [31:0] rng_data,
  output logic [191:0]     tdes_key,
  output logic [255:0]     aes_key,
  output logic             key_ready
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  sla_pkg::sla_phase_t phase_r;
  logic [3:0]  fill_r;
  logic        normal_r;
  logic        test_auth_r;
  logic        flash_r;
  logic        lock_r;
  logic        viol_r;
  logic [3:0]  opr_r;
  logic [31:0] base_r  [sla_pkg::NREG];
  logic [31:0] limit_r [sla_pkg::NREG];
  logic [1:0]  attr_r  [sla_pkg::NREG];
  logic [31:0] key_r   [sla_pkg::KEY_WORDS];
  logic        pready_r;
  logic        pslverr_r;
  logic        grant_r;
  logic        deny_r;
  logic        apdu_acc_r;
  logic        apdu_rej_r;
  logic        tcmd_acc_r;
  logic        tcmd_rej_r;
  logic        set_norm_r;
  logic        set_lock_r;
  logic [31:0] prdata_r;
  logic [31:0] mrdata_r;

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  wire       run     = (phase_r == sla_pkg::PH_RUN);
  wire       test_md = test_auth_r & ~normal_r & run;
  wire       priv    = pprot[0];
  wire       setup   = psel & ~penable;
  wire       wr_acc  = psel & penable & pready_r & pwrite & ~pslverr_r;
  wire       sel_life = (paddr == sla_pkg::OFF_LIFE);
  wire       sel_pass = (paddr == sla_pkg::OFF_PASS);
  wire       sel_boot = (paddr == sla_pkg::OFF_BOOT);
  wire       sel_opr  = (paddr == sla_pkg::OFF_MODESEL);
  wire       sel_stat = (paddr == sla_pkg::OFF_STAT);
  wire [7:0] mpu_off  = paddr - sla_pkg::OFF_MPU;
  wire [7:0] key_off  = paddr - sla_pkg::OFF_KEY;
  wire [1:0] fld      = paddr[3:2];
  wire [1:0] ridx     = mpu_off[5:4];
  wire [3:0] kidx     = key_off[5:2];
  wire       sel_mpu  = (paddr >= sla_pkg::OFF_MPU) & (paddr < sla_pkg::OFF_MPU_E)
                        & (fld != 2'h3);
  wire       sel_key  = (paddr >= sla_pkg::OFF_KEY) & (paddr < sla_pkg::OFF_KEY_E);
  wire       mapped   = sel_life | sel_pass | sel_boot | sel_opr | sel_stat
                        | sel_mpu | sel_key;
  // Password is honoured only before the one-way switch
  wire       pass_ok  = (pwdata == TEST_PASSWORD) & ~normal_r;
  wire [31:0] mpu_rd  = (fld == sla_pkg::FLD_BASE)  ? base_r[ridx] :
                        (fld == sla_pkg::FLD_LIMIT) ? limit_r[ridx] :
                        {30'h0, attr_r[ridx]};
  // Keys and password are write-only so a read never leaks them
  wire [31:0] rd_val  = sel_life ? {31'h0, normal_r} :
                        sel_boot ? {30'h0, lock_r, flash_r} :
                        sel_opr  ? {28'h0, opr_r} :
                        sel_stat ? {27'h0, lock_r, flash_r, normal_r, test_md, viol_r} :
                        sel_mpu  ? mpu_rd : 32'h0;

  // ---------------------------------------------------------------
  // Access check
  // ---------------------------------------------------------------
  wire in_rom   = (mem_addr <= sla_pkg::ROM_HI);
  wire in_flash = (mem_addr >= sla_pkg::FLASH_LO) & (mem_addr <= sla_pkg::FLASH_HI);
  wire in_ram   = (mem_addr >= sla_pkg::RAM_LO) & (mem_addr <= sla_pkg::RAM_HI);
  wire in_trace = (mem_addr >= sla_pkg::TRACE_LO) & in_flash;
  logic [sla_pkg::NREG-1:0] part_hit;
  genvar g;
  for (g = 0; g < sla_pkg::NREG; g++) begin : g_part
    assign part_hit[g] = (mem_addr >= base_r[g]) & (mem_addr <= limit_r[g])
                         & ((g < sla_pkg::NPART) ? in_flash : in_ram)
                         & (mem_we ? attr_r[g][sla_pkg::ATTR_UW]
                                   : attr_r[g][sla_pkg::ATTR_UR]);
  end
  wire bad_addr  = ~(in_rom | in_flash | in_ram);
  wire rom_block = in_rom & (opr_r[sla_pkg::OPR_HIDE]
                   | (mem_user & ~opr_r[sla_pkg::OPR_RUSER]) | mem_we);
  wire fl_block  = in_flash & ((mem_we & opr_r[sla_pkg::OPR_RO])
                   | (mem_user & ~opr_r[sla_pkg::OPR_FUSER]));
  wire tr_block  = in_trace & mem_we & ~test_md;
  wire ld_block  = in_flash & mem_loader & flash_r & lock_r;
  // User mode needs a matching partition
  wire usr_block = mem_user & (in_flash | in_ram) & ~(|part_hit);
  // Nothing is granted until start-up has finished
  wire deny      = ~run | bad_addr | rom_block | fl_block | tr_block | ld_block | usr_block;

  // ---------------------------------------------------------------
  // Start-up: load persistent state, then fill keys
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_r <= sla_pkg::PH_LOAD;
      fill_r  <= 4'h0;
    end else begin
      case (phase_r)
        sla_pkg::PH_LOAD: phase_r <= sla_pkg::PH_FILL;
        sla_pkg::PH_FILL: begin
          // Count stops one past the last key word via the phase change
          fill_r <= fill_r + 4'h1;
          if (fill_r == 4'(sla_pkg::KEY_WORDS - 1)) begin
            phase_r <= sla_pkg::PH_RUN;
          end
        end
        sla_pkg::PH_RUN:  phase_r <= sla_pkg::PH_RUN;
        default:          phase_r <= sla_pkg::PH_LOAD;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Life cycle and boot domain
  // ---------------------------------------------------------------
  // Defaults at power-on reset
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      normal_r    <= 1'b0;
      test_auth_r <= 1'b0;
      flash_r     <= 1'b0;
      lock_r      <= 1'b0;
      set_norm_r  <= 1'b0;
      set_lock_r  <= 1'b0;
    end else begin
      set_norm_r <= 1'b0;
      set_lock_r <= 1'b0;
      if (phase_r == sla_pkg::PH_LOAD) begin
        normal_r <= nv_normal;
        flash_r  <= nv_flash_boot | nv_boot_lock;
        lock_r   <= nv_boot_lock;
      end else if (wr_acc) begin
        if (sel_life & pwdata[0] & ~normal_r) begin
          normal_r   <= 1'b1;
          set_norm_r <= 1'b1;
        end
        if (sel_pass & pass_ok) begin
          test_auth_r <= 1'b1;
        end
        if (sel_boot & ~lock_r) begin
          flash_r <= pwdata[sla_pkg::BOOT_FLASH];
          lock_r  <= pwdata[sla_pkg::BOOT_LOCK] & pwdata[sla_pkg::BOOT_FLASH];
          set_lock_r <= pwdata[sla_pkg::BOOT_LOCK] & pwdata[sla_pkg::BOOT_FLASH];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Attributes, MPU and violation flag
  // ---------------------------------------------------------------
  // Attribute defaults
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      opr_r  <= sla_pkg::OPR_RST;
      viol_r <= 1'b0;
      for (int i = 0; i < sla_pkg::NREG; i++) begin
        base_r[i]  <= sla_pkg::BASE_RST;
        limit_r[i] <= sla_pkg::LIMIT_RST;
        attr_r[i]  <= sla_pkg::ATTR_RST;
      end
    end else begin
      // Hide and read-only only ever set
      if (wr_acc & sel_opr) begin
        opr_r <= {pwdata[3:2], opr_r[1:0] | pwdata[1:0]};
      end
      if (wr_acc & sel_mpu) begin
        if (fld == sla_pkg::FLD_BASE) base_r[ridx] <= pwdata;
        if (fld == sla_pkg::FLD_LIMIT) limit_r[ridx] <= pwdata;
        if (fld == sla_pkg::FLD_ATTR) attr_r[ridx] <= pwdata[1:0];
      end
      if ((mem_req & deny) | (tcmd_valid & ~test_md)) begin
        viol_r <= 1'b1;
      end else if (wr_acc & sel_stat & pwdata[sla_pkg::ST_VIOL]) begin
        viol_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Key registers
  // ---------------------------------------------------------------
  // Random fill, software overwrite
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < sla_pkg::KEY_WORDS; i++) key_r[i] <= sla_pkg::KEY_RST;
      key_ready <= 1'b0;
    end else begin
      key_ready <= run;
      if (phase_r == sla_pkg::PH_FILL) begin
        key_r[fill_r] <= rng_data;
      end else if (wr_acc & sel_key) begin
        key_r[kidx] <= pwdata;
      end
    end
  end
  // Word 0 sits at the low end of each key bus
  for (g = 0; g < sla_pkg::KEY_WORDS; g++) begin : g_key
    if (g < sla_pkg::TDES_WORDS) begin : g_tdes
      assign tdes_key[32*g +: 32] = key_r[g];
    end else begin : g_aes
      assign aes_key[32*(g-sla_pkg::TDES_WORDS) +: 32] = key_r[g];
    end
  end

  // ---------------------------------------------------------------
  // Bus and command answers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
      prdata_r   <= 32'h0;
      grant_r    <= 1'b0;
      deny_r     <= 1'b0;
      mrdata_r   <= 32'h0;
      apdu_acc_r <= 1'b0;
      apdu_rej_r <= 1'b0;
      tcmd_acc_r <= 1'b0;
      tcmd_rej_r <= 1'b0;
    end else begin
      pready_r  <= setup;
      // Unprivileged register access is refused like an unmapped one
      pslverr_r <= setup & ~(mapped & priv & run);
      prdata_r  <= (setup & mapped & priv & ~pwrite) ? rd_val : 32'h0;
      grant_r   <= mem_req & ~deny;
      deny_r    <= mem_req & deny;
      mrdata_r  <= (mem_req & ~deny & ~mem_we) ? mem_rdata_in : 32'h0;
      apdu_acc_r <= apdu_valid & run & ~flash_r;
      apdu_rej_r <= apdu_valid & ~(run & ~flash_r);
      // Test commands only in test mode
      tcmd_acc_r <= tcmd_valid & test_md;
      tcmd_rej_r <= tcmd_valid & ~test_md;
    end
  end

  // Ports mirror the answer flops directly
  assign prdata        = prdata_r;
  assign pready        = pready_r;
  assign pslverr       = pslverr_r;
  assign mem_grant     = grant_r;
  assign mem_deny      = deny_r;
  assign mem_rdata     = mrdata_r;
  assign apdu_accept   = apdu_acc_r;
  assign apdu_reject   = apdu_rej_r;
  assign tcmd_accept   = tcmd_acc_r;
  assign tcmd_reject   = tcmd_rej_r;
  assign nv_set_normal = set_norm_r;
  assign nv_set_lock   = set_lock_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_normal_sticky: assert property (run && normal_r |=> normal_r)
    else $error("normal mode left");

  a_test_password: assert property (
    $rose(test_auth_r) |-> $past(wr_acc && sel_pass && pass_ok))
    else $error("test entry without password");

  a_tcmd_normal: assert property (tcmd_valid && normal_r |=> tcmd_reject && !tcmd_accept)
    else $error("test command taken in normal mode");

  a_tcmd_test: assert property (tcmd_valid && test_md |=> tcmd_accept && !tcmd_reject)
    else $error("test command refused in test mode");

  a_trace_ro: assert property (mem_req && mem_we && in_trace && normal_r |=> mem_deny)
    else $error("traceability write after normal");

  a_boot_lock: assert property (run && lock_r |=> lock_r && $stable(flash_r))
    else $error("boot mode changed after lock");

  a_apdu_flash: assert property (apdu_valid && flash_r |=> apdu_reject && !apdu_accept)
    else $error("loader command in flash boot");

  a_apdu_rom: assert property (
    apdu_valid && run && !flash_r |=> apdu_accept && !apdu_reject)
    else $error("loader command refused in ROM boot");

  a_loader_cut: assert property (
    mem_req && mem_loader && in_flash && lock_r |=> mem_deny)
    else $error("loader reached flash after lock");

  a_rom_hidden: assert property (
    mem_req && in_rom && opr_r[sla_pkg::OPR_HIDE] |=> mem_deny && mem_rdata == 32'h0)
    else $error("hidden ROM reached");

  a_flash_ro: assert property (
    mem_req && mem_we && in_flash && opr_r[sla_pkg::OPR_RO] |=> !mem_grant)
    else $error("flash write while read-only");

  a_user_part: assert property (mem_req && mem_user && in_ram && !(|part_hit) |=> mem_deny)
    else $error("user access outside partitions");

  a_bad_addr: assert property (mem_req && bad_addr |=> mem_deny && !mem_grant)
    else $error("invalid address granted");

  a_deny_flag: assert property (mem_deny |-> viol_r ##1 viol_r)
    else $error("denial without violation flag");

  a_deny_empty: assert property (mem_deny |-> mem_rdata == 32'h0)
    else $error("denied access returned data");

  a_key_fill: assert property ($rose(run) |-> key_ready == 1'b0 ##1 key_ready)
    else $error("keys not ready after fill");

  a_key_wr: assert property (wr_acc && sel_key |=> key_r[$past(kidx)] == $past(pwdata))
    else $error("key overwrite lost");

  c_test_entry: cover property ($rose(test_auth_r));
  c_boot_lock:  cover property ($rose(lock_r));
  c_rom_hide:   cover property (mem_req && in_rom && opr_r[sla_pkg::OPR_HIDE] ##1 mem_deny);
  c_key_write:  cover property (wr_acc && sel_key);
  c_normal_in:  cover property ($rose(normal_r));
endmodule // sla_ctrl
`default_nettype wire

// >>> sla_mem_model.sv
// Purpose: Far-side memory and entropy source that answers sla_ctrl
// Assumes: Read data is valid only in the request cycle
// Notes:   Idle data toggles every cycle so a stale value never matches
`timescale 1ns/1ns
`default_nettype none
module sla_mem_model (
  input  wire logic        core_clk,
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  output logic [31:0]      mem_rdata_in,
  output logic [31:0]      rng_data
);
  // ---------------------------------------------------------------
  // Memory content and entropy
  // ---------------------------------------------------------------
  logic [31:0] idle_r;
  initial idle_r = 32'h0f0f_0f0f;
  initial rng_data = 32'h1357_0000;
  // Content tied to address so a misrouted read shows up
  assign mem_rdata_in = mem_req ? (mem_addr ^ 32'hc3c3_3c3c) : idle_r;
  // Counting entropy lets the bench check fill order without alignment
  always @(posedge core_clk) begin
    idle_r   <= ~idle_r;
    rng_data <= rng_data + 32'h1;
  end
endmodule // sla_mem_model
`default_nettype wire

// >>> sla_ctrl_tb.sv
// Purpose: Self-checking bench for sla_ctrl
// Assumes: Zero-wait APB, one-cycle memory and command answers
// Notes:   Hide and read-only stick until reset, so they are set last
`timescale 1ns/1ns
`default_nettype none
module sla_ctrl_tb;
  localparam logic [31:0] PASSWORD = 32'h6e21_9b04;  // arbitrary value
  localparam logic [31:0] MEMX     = 32'hc3c3_3c3c;
  logic         core_clk, rst_b, psel, penable, pwrite;
  logic [7:0]   paddr;
  logic [2:0]   pprot;
  logic [31:0]  pwdata, prdata, mem_addr, mem_rdata_in, mem_rdata, rng_data, rd;
  logic         pready, pslverr, mem_req, mem_we, mem_user, mem_loader, err;
  logic         mem_grant, mem_deny, apdu_valid, apdu_accept, apdu_reject;
  logic         tcmd_valid, tcmd_accept, tcmd_reject, nv_normal, nv_flash_boot;
  logic         nv_boot_lock, nv_set_normal, nv_set_lock, key_ready;
  logic [191:0] tdes_key;
  logic [255:0] aes_key;
  logic [447:0] all_key;
  int           n_errors, total_checks;

  initial core_clk = 1'b0;
  always #4 core_clk = ~core_clk;
  assign all_key = {aes_key, tdes_key};

  sla_ctrl #(.TEST_PASSWORD(PASSWORD)) dut (
    .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pprot(pprot),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
    .mem_we(mem_we), .mem_user(mem_user), .mem_loader(mem_loader),
    .mem_addr(mem_addr), .mem_rdata_in(mem_rdata_in), .mem_grant(mem_grant),
    .mem_deny(mem_deny), .mem_rdata(mem_rdata), .apdu_valid(apdu_valid),
    .apdu_accept(apdu_accept), .apdu_reject(apdu_reject),
    .tcmd_valid(tcmd_valid), .tcmd_accept(tcmd_accept),
    .tcmd_reject(tcmd_reject), .nv_normal(nv_normal),
    .nv_flash_boot(nv_flash_boot), .nv_boot_lock(nv_boot_lock),
    .nv_set_normal(nv_set_normal), .nv_set_lock(nv_set_lock),
    .rng_data(rng_data), .tdes_key(tdes_key), .aes_key(aes_key),
    .key_ready(key_ready));

  sla_mem_model far_end (
    .core_clk(core_clk), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_rdata_in(mem_rdata_in), .rng_data(rng_data));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [2:0] pr);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pprot   <= pr;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Kind k is {loader, user, write}
  task automatic mem(input logic [2:0] k, input logic [31:0] a, input logic g);
    @(posedge core_clk);
    mem_req    <= 1'b1;
    mem_we     <= k[0];
    mem_user   <= k[1];
    mem_loader <= k[2];
    mem_addr   <= a;
    @(posedge core_clk);
    mem_req <= 1'b0;
    @(posedge core_clk);
    chk({30'h0, mem_grant, mem_deny}, {30'h0, g, !g});
    chk(mem_rdata, (g && !k[0]) ? (a ^ MEMX) : 32'h0);
  endtask

  task automatic cmd(input logic ap, input logic acc);
    @(posedge core_clk);
    apdu_valid <= ap;
    tcmd_valid <= !ap;
    @(posedge core_clk);
    apdu_valid <= 1'b0;
    tcmd_valid <= 1'b0;
    @(posedge core_clk);
    chk({30'h0, ap ? {apdu_accept, apdu_reject} : {tcmd_accept, tcmd_reject}},
        {30'h0, acc, !acc});
  endtask

  task automatic do_reset(input logic [2:0] nv);
    int n;
    n = 0;
    {nv_boot_lock, nv_flash_boot, nv_normal} <= nv;
    rst_b <= 1'b0;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    while (key_ready !== 1'b1) begin
      @(posedge core_clk);
      n++;
    end
    chk(32'(n), 32'h11);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_keys;
    for (int i = 0; i < 13; i++)
      chk(all_key[32*i+32 +: 32], all_key[32*i +: 32] + 32'h1);
    apb(1'b1, 8'h80, 32'h0bad_f00d, 3'h1);
    @(posedge core_clk);
    chk(tdes_key[31:0], 32'h0bad_f00d);
    apb(1'b1, 8'h98, 32'h600d_cafe, 3'h1);
    @(posedge core_clk);
    chk(aes_key[31:0], 32'h600d_cafe);
    apb(1'b0, 8'h80, 32'h0, 3'h1);
    chk(rd, 32'h0);
  endtask

  task automatic t_defaults;
    apb(1'b0, 8'h0c, 32'h0, 3'h1);
    chk(rd, 32'hc);
    apb(1'b0, 8'h48, 32'h0, 3'h1);
    chk(rd, 32'h0);
    apb(1'b0, 8'h4c, 32'h0, 3'h1);
    chk1(err, 1'b1);
    apb(1'b0, 8'h0c, 32'h0, 3'h0);
    chk({err, rd[30:0]}, 32'h8000_0000);
  endtask

  task automatic t_mpu;
    mem(3'b010, 32'h0010_0100, 1'b0);
    apb(1'b1, 8'h40, 32'h0010_0000, 3'h1);
    apb(1'b1, 8'h44, 32'h0010_0fff, 3'h1);
    apb(1'b1, 8'h48, 32'h1, 3'h1);
    mem(3'b010, 32'h0010_0100, 1'b1);
    mem(3'b011, 32'h0010_0100, 1'b0);
    mem(3'b010, 32'h0010_1000, 1'b0);
    apb(1'b1, 8'h60, 32'h0020_0000, 3'h1);
    apb(1'b1, 8'h64, 32'h0020_00ff, 3'h1);
    apb(1'b1, 8'h68, 32'h3, 3'h1);
    mem(3'b011, 32'h0020_0010, 1'b1);
    mem(3'b010, 32'h0020_0100, 1'b0);
    mem(3'b000, 32'h0030_0000, 1'b0);
    apb(1'b0, 8'h10, 32'h0, 3'h1);
    chk1(rd[0], 1'b1);
    apb(1'b1, 8'h10, 32'h1, 3'h1);
    apb(1'b0, 8'h10, 32'h0, 3'h1);
    chk1(rd[0], 1'b0);
    mem(3'b010, 32'h0000_0040, 1'b1);
    apb(1'b1, 8'h0c, 32'h8, 3'h1);
    mem(3'b010, 32'h0000_0040, 1'b0);
    mem(3'b000, 32'h0000_0040, 1'b1);
  endtask

  task automatic t_life;
    cmd(1'b0, 1'b0);
    apb(1'b1, 8'h04, PASSWORD ^ 32'h1, 3'h1);
    cmd(1'b0, 1'b0);
    apb(1'b1, 8'h04, PASSWORD, 3'h1);
    cmd(1'b0, 1'b1);
    mem(3'b001, 32'h001f_f010, 1'b1);
    apb(1'b1, 8'h00, 32'h1, 3'h1);
    @(posedge core_clk);
    chk1(nv_set_normal, 1'b1);
    @(posedge core_clk);
    chk1(nv_set_normal, 1'b0);
    cmd(1'b0, 1'b0);
    apb(1'b1, 8'h04, PASSWORD, 3'h1);
    cmd(1'b0, 1'b0);
    apb(1'b1, 8'h00, 32'h0, 3'h1);
    apb(1'b0, 8'h00, 32'h0, 3'h1);
    chk1(rd[0], 1'b1);
    mem(3'b001, 32'h001f_f010, 1'b0);
    mem(3'b000, 32'h001f_f010, 1'b1);
  endtask

  task automatic t_boot;
    cmd(1'b1, 1'b1);
    mem(3'b100, 32'h0010_0200, 1'b1);
    apb(1'b1, 8'h08, 32'h3, 3'h1);
    @(posedge core_clk);
    chk1(nv_set_lock, 1'b1);
    @(posedge core_clk);
    chk1(nv_set_lock, 1'b0);
    cmd(1'b1, 1'b0);
    mem(3'b100, 32'h0010_0200, 1'b0);
    mem(3'b101, 32'h0010_0200, 1'b0);
    apb(1'b1, 8'h08, 32'h0, 3'h1);
    apb(1'b0, 8'h10, 32'h0, 3'h1);
    chk({30'h0, rd[4:3]}, 32'h3);
  endtask

  task automatic t_attr;
    mem(3'b001, 32'h0010_0300, 1'b1);
    apb(1'b1, 8'h0c, 32'ha, 3'h1);
    mem(3'b001, 32'h0010_0300, 1'b0);
    mem(3'b000, 32'h0010_0300, 1'b1);
    apb(1'b1, 8'h0c, 32'hb, 3'h1);
    mem(3'b000, 32'h0000_0080, 1'b0);
  endtask

  task automatic t_persist;
    do_reset(3'b111);
    chk(all_key[63:32], all_key[31:0] + 32'h1);
    apb(1'b0, 8'h10, 32'h0, 3'h1);
    chk({29'h0, rd[4:2]}, 32'h7);
    apb(1'b0, 8'h0c, 32'h0, 3'h1);
    chk(rd, 32'hc);
    apb(1'b0, 8'h64, 32'h0, 3'h1);
    chk(rd, 32'h0);
    cmd(1'b0, 1'b0);
    mem(3'b000, 32'h0000_0080, 1'b1);
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata, pprot} = '0;
    {mem_req, mem_we, mem_user, mem_loader, mem_addr} = '0;
    {apdu_valid, tcmd_valid, nv_normal, nv_flash_boot, nv_boot_lock} = '0;
    n_errors = 0;
    total_checks = 0;
    do_reset(3'b000);
    t_keys;
    t_defaults;
    t_mpu;
    t_life;
    t_boot;
    t_attr;
    t_persist;
    tally_and_finish;
  end

  // Whole run is under two thousand cycles
  initial begin
    #100000;
    n_errors++;
    tally_and_finish;
  end
endmodule // sla_ctrl_tb
`default_nettype wire
